// ### design/ddi_decode.sv
/*
 * Digital-input function decoder: five terminals, each with a programmed
 * function code, turned into drive command levels and pulses.
 * Assumes asynchronous terminal levels and a plain register port.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RULE_01] One function code per terminal, codes 0 to 36.
// [RULE_02] Defaults: start, reverse, freewheel-and-clear, fixed speed, none.
// [RULE_03] Code 0 terminal has no effect at all.
// [RULE_04] Code 1 rising edge clears alarm; trip-locked alarms stay.
// [RULE_05] Code 2 low level coasts the motor immediately.
// [RULE_06] Code 3 low coasts; falling edge also clears alarm.
// [RULE_07] Code 4 low starts quick-stop ramp.
// [RULE_08] Code 5 low brakes with DC only if time and voltage nonzero.
// [RULE_09] Code 6 low ramps down to standstill.
// [RULE_10] Code 7 high runs, low stops.
// [RULE_11] Code 8 pulse of 14 ms latches run; stop input clears.
// [RULE_12] Code 9 high reverses without start; off in closed loop.
// [RULE_13] Code 10 runs and reverses; off in closed loop.
// [RULE_14] Codes 11 and 12 limit rotation to one direction.
// [RULE_15] Code 13 forces fixed speed unless coast, quick stop, DC brake.
// [RULE_16] Code 14 holds reference; only speed up/down change it.
// [RULE_17] Code 15 holds output frequency; only up/down change it.
// [RULE_18] Fourth terminal refuses pulse codes while output is pulse.
// [RULE_19] Encoder codes only on terminals four and five, set together.
// [RULE_20] Each 14 ms up/down pulse steps the held value once.
// [RULE_21] Ramp select low picks ramp pair one, high pair two.
// [RULE_22] Two preset inputs form index, MSB input most significant.
// [RULE_23] Terminals synchronised; edges taken on synchronised signal.
// [RULE_24] Writes of codes a terminal does not offer are refused.
module ddi_decode #(
   parameter int MIN_PULSE = ddi_pkg::MIN_PULSE_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        clkEn,
   input  wire logic [4:0]  terminalPin,
   input  wire logic [3:0]  regAddr,
   input  wire logic [15:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [15:0] regRdata,
   input  wire logic        tripLocked,
   output logic             alarmClear,
   output logic             coastCmd,
   output logic             quickStopCmd,
   output logic             dcBrakeCmd,
   output logic             rampStopCmd,
   output logic             runCmd,
   output logic             reverseCmd,
   output logic             onlyCw,
   output logic             onlyCcw,
   output logic             fixedSpeed,
   output logic             holdRef,
   output logic             holdOut,
   output logic             speedUpStep,
   output logic             speedDownStep,
   output logic             rampSel,
   output logic [1:0]       presetIdx,
   output logic             encoderMode
);
   // *****************************************************************
   // Parameter check
   // *****************************************************************
   // Refused at elaboration: a one-cycle pulse could not be timed
   if (MIN_PULSE < 2) begin : gBadPulse
      $error("MIN_PULSE must be at least 2");
   end

   // *****************************************************************
   // Terminal synchronisers
   // *****************************************************************
   logic [4:0] syncA;
   logic [4:0] syncB;
   logic [4:0] syncC;
   logic [4:0] level;
   logic [4:0] levelPrev;

   // Three stages; level changes once second and third agree
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         syncA     <= 5'h1F;
         syncB     <= 5'h1F;
         syncC     <= 5'h1F;
         level     <= 5'h1F;
         levelPrev <= 5'h1F;
      end else if (clkEn) begin
         syncA     <= terminalPin;
         syncB     <= syncA;
         syncC     <= syncB;
         level     <= (syncB & syncC) | (level & (syncB | syncC)); // RULE_23
         levelPrev <= level;
      end
   end

   wire [4:0] rise = level & ~levelPrev;   // RULE_23
   wire [4:0] fall = ~level & levelPrev;

   // *****************************************************************
   // Configuration registers
   // *****************************************************************
   logic [5:0]  fnCode [5];
   logic        pulseOutCfg;
   logic        closedLoop;
   logic [15:0] dcTime;
   logic [15:0] dcVolt;
   logic [15:0] upCount;
   logic [15:0] downCount;

   // Code legality per terminal; gaps 18 and 25 never offered
   function automatic logic codeOk(input int term, input logic [5:0] c,
                                   input logic pulseOut);
      logic ok;
      ok = (c <= ddi_pkg::FN_ENC_LAST)                      // RULE_01
         && c != ddi_pkg::FN_UNUSED_18 && c != ddi_pkg::FN_UNUSED_25;
      if ((c == ddi_pkg::FN_PRECISE_LO || c == ddi_pkg::FN_PRECISE_HI)
          && term > 1) begin
         ok = 1'b0;                                         // RULE_24
      end
      if ((c == ddi_pkg::FN_PULSE_REF || c == ddi_pkg::FN_PULSE_FB)
          && term < 3) begin
         ok = 1'b0;
      end
      if ((c == ddi_pkg::FN_PULSE_REF || c == ddi_pkg::FN_PULSE_FB)
          && term == 3 && pulseOut) begin
         ok = 1'b0;                                         // RULE_18
      end
      if (c == ddi_pkg::FN_PULSE_IN && term != 4) begin
         ok = 1'b0;
      end
      if (c >= ddi_pkg::FN_ENC_FIRST && term < 3) begin
         ok = 1'b0;                                         // RULE_19
      end
      return ok;
   endfunction : codeOk

   wire        fnWr    = regWr && regAddr <= ddi_pkg::REG_FN4;
   wire [2:0]  fnIdx   = regAddr[2:0];
   wire        wrEnc   = regWdata[5:0] >= ddi_pkg::FN_ENC_FIRST
                         && regWdata[5:0] <= ddi_pkg::FN_ENC_LAST;
   wire [5:0]  wrCode  = regWdata[5:0];
   wire        wrHigh  = |regWdata[15:6];
   wire        encPrev = fnCode[3] >= ddi_pkg::FN_ENC_FIRST;

   // Function code writes; encoder pair written as one
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         fnCode[0] <= ddi_pkg::RST_FN0;                    // RULE_02
         fnCode[1] <= ddi_pkg::RST_FN1;
         fnCode[2] <= ddi_pkg::RST_FN2;
         fnCode[3] <= ddi_pkg::RST_FN3;
         fnCode[4] <= ddi_pkg::RST_FN4;
      end else if (clkEn && fnWr && !wrHigh
                   && codeOk(int'(fnIdx), wrCode, pulseOutCfg)) begin
         if (wrEnc) begin
            fnCode[3] <= wrCode;                           // RULE_19
            fnCode[4] <= wrCode;
         end else begin
            fnCode[fnIdx] <= wrCode;
            // Leaving encoder mode on one terminal frees the partner
            if (encPrev && (fnIdx == 3'h3 || fnIdx == 3'h4)) begin
               fnCode[3'h7 - fnIdx] <= ddi_pkg::FN_NONE;
            end
         end
      end
   end

   // Other settings
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pulseOutCfg <= 1'b0;
         closedLoop  <= 1'b0;
         dcTime      <= ddi_pkg::RST_DC_TIME;
         dcVolt      <= ddi_pkg::RST_DC_VOLT;
      end else if (clkEn && regWr) begin
         if (regAddr == ddi_pkg::REG_CFG) begin
            pulseOutCfg <= regWdata[ddi_pkg::CFG_PULSE_OUT];
            closedLoop  <= regWdata[ddi_pkg::CFG_CLOSED_LOOP];
         end
         if (regAddr == ddi_pkg::REG_DC_TIME) begin
            dcTime <= regWdata;
         end
         if (regAddr == ddi_pkg::REG_DC_VOLT) begin
            dcVolt <= regWdata;
         end
      end
   end

   // *****************************************************************
   // Per-terminal function decode
   // *****************************************************************
   logic [4:0] isFn [37];
   genvar g;
   genvar t;
   generate
      for (g = 0; g < 37; g++) begin : gFn
         for (t = 0; t < 5; t++) begin : gTerm
            // Code 0 matches nothing that is read below
            assign isFn[g][t] = (fnCode[t] == 6'(g));       // RULE_03
         end
      end
   endgenerate

   wire anyLow[37];
   wire anyHigh[37];
   generate
      for (g = 0; g < 37; g++) begin : gAny
         assign anyLow[g]  = |(isFn[g] & ~level);
         assign anyHigh[g] = |(isFn[g] & level);
      end
   endgenerate

   // *****************************************************************
   // Stop commands and alarm clear
   // *****************************************************************
   wire coastNow = anyLow[2] || anyLow[3];                 // RULE_05 RULE_06
   wire dcArmed  = dcTime != 16'h0000 && dcVolt != 16'h0000;
   wire dcNow    = anyLow[5] && dcArmed;                   // RULE_08
   wire qsNow    = anyLow[4];                              // RULE_07
   wire stopNow  = anyLow[6];                              // RULE_09
   wire clearEv  = |((isFn[1] & rise) | (isFn[3] & fall)); // RULE_04 RULE_06

   // *****************************************************************
   // Pulse-width measurement, a high counter and a low counter per terminal
   // *****************************************************************
   localparam int CW = $clog2(MIN_PULSE + 1);
   logic [CW-1:0] highCnt [5];
   logic [CW-1:0] lowCnt  [5];
   logic [4:0]    longHigh;
   logic [4:0]    lowOk;
   logic [4:0]    stepArmed;

   generate
      for (t = 0; t < 5; t++) begin : gCnt
         // Counts saturate; low time gates the next step
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               highCnt[t]   <= '0;
               lowCnt[t]    <= '0;
               stepArmed[t] <= 1'b1;
            end else if (clkEn) begin
               if (level[t]) begin
                  lowCnt[t] <= '0;
                  if (highCnt[t] != CW'(MIN_PULSE)) begin
                     highCnt[t] <= highCnt[t] + 1'b1;
                  end
               end else begin
                  highCnt[t] <= '0;
                  if (lowCnt[t] != CW'(MIN_PULSE)) begin
                     lowCnt[t] <= lowCnt[t] + 1'b1;
                  end
               end
               if (longHigh[t]) begin
                  stepArmed[t] <= 1'b0;
               end else if (lowOk[t]) begin
                  stepArmed[t] <= 1'b1;                     // RULE_20
               end
            end
         end
         assign longHigh[t] = highCnt[t] == CW'(MIN_PULSE - 1) && level[t];
         assign lowOk[t]    = lowCnt[t] == CW'(MIN_PULSE);
      end
   endgenerate

   // *****************************************************************
   // Run, latch and direction
   // *****************************************************************
   logic latched;
   wire anyStop   = stopNow || coastNow || qsNow || dcNow;
   wire latchHit  = |(isFn[8] & longHigh);                 // RULE_11
   wire revAllowed = !closedLoop;
   wire next_latched = anyStop ? 1'b0 : (latched || latchHit);

   // Latched start; stop wins over the start pulse
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         latched <= 1'b0;
      end else if (clkEn) begin
         latched <= next_latched;                          // RULE_11
      end
   end

   wire runLevel = anyHigh[7]                              // RULE_10
                 || (anyHigh[10] && revAllowed);           // RULE_13
   wire revLevel = revAllowed && (anyHigh[9] || anyHigh[10]); // RULE_12

   wire stepUp   = |(isFn[16] & longHigh & stepArmed);
   wire stepDown = |(isFn[17] & longHigh & stepArmed);
   wire frozen   = |isFn[14] || |isFn[15];

   // *****************************************************************
   // Registered command outputs
   // *****************************************************************
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         alarmClear    <= 1'b0;
         coastCmd      <= 1'b0;
         quickStopCmd  <= 1'b0;
         dcBrakeCmd    <= 1'b0;
         rampStopCmd   <= 1'b0;
         runCmd        <= 1'b0;
         reverseCmd    <= 1'b0;
         onlyCw        <= 1'b0;
         onlyCcw       <= 1'b0;
         fixedSpeed    <= 1'b0;
         holdRef       <= 1'b0;
         holdOut       <= 1'b0;
         speedUpStep   <= 1'b0;
         speedDownStep <= 1'b0;
         rampSel       <= 1'b0;
         presetIdx     <= 2'b00;
         encoderMode   <= 1'b0;
      end else if (clkEn) begin
         alarmClear   <= clearEv && !tripLocked;           // RULE_04
         coastCmd     <= coastNow;                         // RULE_05
         quickStopCmd <= qsNow;                            // RULE_07
         dcBrakeCmd   <= dcNow;                            // RULE_08
         rampStopCmd  <= stopNow;                          // RULE_09
         runCmd       <= (runLevel || next_latched) && !anyStop;
         reverseCmd   <= revLevel;                         // RULE_12
         onlyCw       <= anyHigh[11];                      // RULE_14
         onlyCcw      <= anyHigh[12];                      // RULE_14
         // Fixed speed blocked by coast, quick stop and DC brake
         fixedSpeed   <= anyHigh[13] && !coastNow && !qsNow && !dcNow; // RULE_15
         holdRef      <= anyHigh[14];                      // RULE_16
         holdOut      <= anyHigh[15];                      // RULE_17
         // Simultaneous up and down resolves to down
         speedUpStep   <= frozen && stepUp && !stepDown;   // RULE_20
         speedDownStep <= frozen && stepDown;              // RULE_20
         rampSel      <= anyHigh[21];                      // RULE_21
         presetIdx    <= {anyHigh[23], anyHigh[22]};       // RULE_22
         encoderMode  <= fnCode[3] >= ddi_pkg::FN_ENC_FIRST; // RULE_19
      end
   end

   // Step counters give software a view of frozen-value changes
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         upCount   <= ddi_pkg::RST_STEP;
         downCount <= ddi_pkg::RST_STEP;
      end else if (clkEn) begin
         if (speedUpStep) begin
            upCount <= upCount + 16'h0001;
         end
         if (speedDownStep) begin
            downCount <= downCount + 16'h0001;
         end
      end
   end

   // *****************************************************************
   // Register read port, data one cycle after the strobe
   // *****************************************************************
   wire [15:0] statusWord = {4'h0, encoderMode, presetIdx, rampSel,
                             holdOut, holdRef, fixedSpeed, reverseCmd,
                             runCmd, dcBrakeCmd, quickStopCmd, coastCmd};
   wire [15:0] rdMux =
      (regAddr <= ddi_pkg::REG_FN4) ? {10'h000, fnCode[fnIdx]} :
      (regAddr == ddi_pkg::REG_CFG) ? {14'h0000, closedLoop, pulseOutCfg} :
      (regAddr == ddi_pkg::REG_DC_TIME) ? dcTime :
      (regAddr == ddi_pkg::REG_DC_VOLT) ? dcVolt :
      (regAddr == ddi_pkg::REG_STATUS) ? statusWord :
      (regAddr == ddi_pkg::REG_STEPS) ? {upCount[7:0], downCount[7:0]} :
      (regAddr == ddi_pkg::REG_LEVELS) ? {11'h000, level} : 16'h0000;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         regRdata <= 16'h0000;
      end else if (clkEn) begin
         regRdata <= regRd ? rdMux : 16'h0000;
      end
   end

   // *****************************************************************
   // Checks
   // *****************************************************************
   dc_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_08
      dcBrakeCmd |-> $past(dcArmed))
      else $error("DC brake with zero time or voltage");
   jog_block_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_15
      (fixedSpeed |-> !coastCmd && !quickStopCmd && !dcBrakeCmd))
      else $error("Fixed speed active during stop");
   stop_run_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_11
      (clkEn && anyStop) |=> !runCmd)
      else $error("Run while a stop command is present");
   rev_loop_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_12
      (clkEn && closedLoop && $stable(closedLoop)) |=> !reverseCmd)
      else $error("Reverse in closed loop");
   enc_pair_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_19
      (fnCode[3] >= ddi_pkg::FN_ENC_FIRST) |-> fnCode[4] == fnCode[3])
      else $error("Encoder pair differs");
   code_range_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_01
      (regAddr <= ddi_pkg::REG_FN4) |-> fnCode[fnIdx] <= ddi_pkg::FN_ENC_LAST)
      else $error("Function code out of range");
   clear_trip_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_04
      alarmClear |-> !$past(tripLocked))
      else $error("Alarm cleared while trip-locked");
   step_once_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_20
      speedUpStep |=> !speedUpStep)
      else $error("Double speed step");
   coast_low_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_05
      (clkEn && isFn[2][0] && !level[0]) |=> coastCmd)
      else $error("Coast missed on low level");
endmodule : ddi_decode

`default_nettype wire

// ### shared/ddi_pkg.sv
/*
 * Constants for the digital-input function decoder: function codes,
 * default terminal settings, register offsets and timing figures.
 * Assumes a single 125 MHz control clock.
 */
package ddi_pkg;
   // *****************************************************************
   // Function codes
   // *****************************************************************
   localparam logic [5:0] FN_NONE       = 6'h00;
   localparam logic [5:0] FN_RESET      = 6'h01;
   localparam logic [5:0] FN_COAST_LOW  = 6'h02;
   localparam logic [5:0] FN_FREEWHEEL_AND_CLEAR_LOW = 6'h03;
   localparam logic [5:0] FN_QSTOP_LOW  = 6'h04;
   localparam logic [5:0] FN_DC_INJECTION_HALT_LOW = 6'h05;
   localparam logic [5:0] FN_STOP_LOW   = 6'h06;
   localparam logic [5:0] FN_START      = 6'h07;
   localparam logic [5:0] FN_LATCH_START = 6'h08;
   localparam logic [5:0] FN_REVERSE    = 6'h09;
   localparam logic [5:0] FN_START_REV  = 6'h0A;
   localparam logic [5:0] FN_ONLY_CW    = 6'h0B;
   localparam logic [5:0] FN_ONLY_CCW   = 6'h0C;
   localparam logic [5:0] FN_FIXED_SPEED_OVERRIDE = 6'h0D;
   localparam logic [5:0] FN_HOLD_REF   = 6'h0E;
   localparam logic [5:0] FN_HOLD_OUT   = 6'h0F;
   localparam logic [5:0] FN_SPEED_UP   = 6'h10;
   localparam logic [5:0] FN_SPEED_DOWN = 6'h11;
   localparam logic [5:0] FN_RAMP_SEL   = 6'h15;
   localparam logic [5:0] FN_PRESET_LSB = 6'h16;
   localparam logic [5:0] FN_PRESET_MSB = 6'h17;
   localparam logic [5:0] FN_PRECISE_LO = 6'h1A;
   localparam logic [5:0] FN_PRECISE_HI = 6'h1B;
   localparam logic [5:0] FN_PULSE_REF  = 6'h1C;
   localparam logic [5:0] FN_PULSE_FB   = 6'h1D;
   localparam logic [5:0] FN_PULSE_IN   = 6'h1E;
   localparam logic [5:0] FN_ENC_FIRST  = 6'h22;
   localparam logic [5:0] FN_ENC_LAST   = 6'h24;
   localparam logic [5:0] FN_UNUSED_18  = 6'h12;
   localparam logic [5:0] FN_UNUSED_25  = 6'h19;

   // *****************************************************************
   // Values after reset, terminal order 0..4
   // *****************************************************************
   localparam logic [5:0] RST_FN0 = FN_START;
   localparam logic [5:0] RST_FN1 = FN_REVERSE;
   localparam logic [5:0] RST_FN2 = FN_FREEWHEEL_AND_CLEAR_LOW;
   localparam logic [5:0] RST_FN3 = FN_FIXED_SPEED_OVERRIDE;
   localparam logic [5:0] RST_FN4 = FN_NONE;
   localparam logic [15:0] RST_DC_TIME = 16'h0000;
   localparam logic [15:0] RST_DC_VOLT = 16'h0000;
   localparam logic [15:0] RST_STEP    = 16'h0000;

   // *****************************************************************
   // Register offsets (word index on the plain port)
   // *****************************************************************
   localparam logic [3:0] REG_FN0     = 4'h0;
   localparam logic [3:0] REG_FN4     = 4'h4;
   localparam logic [3:0] REG_CFG     = 4'h5;
   localparam logic [3:0] REG_DC_TIME = 4'h6;
   localparam logic [3:0] REG_DC_VOLT = 4'h7;
   localparam logic [3:0] REG_STATUS  = 4'h8;
   localparam logic [3:0] REG_STEPS   = 4'h9;
   localparam logic [3:0] REG_LEVELS  = 4'hA;
   localparam int CFG_PULSE_OUT  = 0;
   localparam int CFG_CLOSED_LOOP = 1;

   // *****************************************************************
   // Timing
   // *****************************************************************
   localparam int CLK_MHZ        = 125;
   localparam int MIN_PULSE_MS   = 14;
   localparam int MIN_PULSE_CYC  = MIN_PULSE_MS * 1000 * CLK_MHZ;
endpackage : ddi_pkg

// ### tb/ddi_term_drv.sv
/* Far-side model: switch contacts on the five terminals.
 * Assumes the bench asks for levels and holds each pulse long enough. */
`timescale 1ns/1ps
`default_nettype none
module ddi_term_drv (
   input  wire logic       core_clk,
   input  wire logic [4:0] want,
   output logic      [4:0] terminalPin
);
   // Contacts change just after the clock edge; widths are the bench's
   always_ff @(posedge core_clk) begin
      terminalPin <= want;
   end
endmodule : ddi_term_drv
`default_nettype wire

// ### tb/drive_digital_input_functions_tb_top.sv
/* Bench for the terminal function decoder: register tasks and terminal
 * scenarios. Assumes ddi_pkg is compiled first; MIN_PULSE cut to 20. */
`timescale 1ns/1ps
`default_nettype none
module drive_digital_input_functions_tb_top;
   localparam int MP = 20;
   logic core_clk = 0, sys_rst = 1, regWr = 0, regRd = 0;
   logic [3:0] regAddr = 4'h0;
   logic [15:0] regWdata = 16'h0000, regRdata;
   logic [4:0] want = 5'b00100, terminalPin;
   logic tripLocked = 0, alarmClear, coastCmd, runCmd, reverseCmd;
   logic speedUpStep, encoderMode;
   logic [1:0] presetIdx;
   int nMismatch = 0, nCompared = 0, nClr = 0, nUp = 0;
   // ****************************************************************
   // Clock, partner and design
   // ****************************************************************
   initial forever #4 core_clk = ~core_clk;
   ddi_term_drv ddi_term_drv_i (.core_clk(core_clk), .want(want),
      .terminalPin(terminalPin));
   ddi_decode #(.MIN_PULSE(MP)) ddi_decode_i (.core_clk(core_clk),
      .sys_rst(sys_rst), .clkEn(1'b1), .terminalPin(terminalPin),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .tripLocked(tripLocked),
      .alarmClear(alarmClear), .coastCmd(coastCmd), .quickStopCmd(),
      .dcBrakeCmd(), .rampStopCmd(), .runCmd(runCmd),
      .reverseCmd(reverseCmd), .onlyCw(), .onlyCcw(), .fixedSpeed(),
      .holdRef(), .holdOut(), .speedUpStep(speedUpStep),
      .speedDownStep(), .rampSel(), .presetIdx(presetIdx),
      .encoderMode(encoderMode));
   // Pulse counters, one-cycle outputs seen in their own cycle
   always @(posedge core_clk) begin
      if (alarmClear === 1'b1) nClr++;
      if (speedUpStep === 1'b1) nUp++;
   end
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task chk(input logic [15:0] got, input logic [15:0] exp);
      nCompared++;
      if (got !== exp) begin
         nMismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regWr <= 1; regAddr <= a; regWdata <= d;
      @(posedge core_clk);
      regWr <= 0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge core_clk);
      regRd <= 1; regAddr <= a;
      @(posedge core_clk);
      regRd <= 0;
      @(negedge core_clk);
      chk(regRdata, e);
   endtask : rd
   // Level change, then a wait of n falling edges; seven or more cover sync and output flops
   task pin(input logic [4:0] w, input int n);
      @(posedge core_clk);
      want <= w;
      repeat (n) @(negedge core_clk);
   endtask : pin
   task tally_and_finish;
      if (nMismatch == 0 && nCompared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      repeat (2) @(posedge core_clk);
      sys_rst <= 0;
      rd(4'h0, 16'h0007); rd(4'h1, 16'h0009); rd(4'h2, 16'h0003);
      rd(4'h3, 16'h000D); rd(4'h4, 16'h0000);
      pin(5'b00101, 10); chk(runCmd, 1); chk(reverseCmd, 0);
      pin(5'b00110, 10); chk(runCmd, 0); chk(reverseCmd, 1);
      pin(5'b00010, 10); chk(coastCmd, 1); chk(nClr, 1);
      @(posedge core_clk) tripLocked <= 1;
      pin(5'b00110, 10); pin(5'b00010, 10); chk(nClr, 1);
      @(posedge core_clk) tripLocked <= 0;
      pin(5'b10100, 10); chk(runCmd, 0); chk(coastCmd, 0);
      wr(4'h0, 16'h0012); rd(4'h0, 16'h0007);
      wr(4'h0, 16'h001C); rd(4'h0, 16'h0007);
      wr(4'h3, 16'h0022); rd(4'h4, 16'h0022);
      pin(5'b00100, 4); chk(encoderMode, 1);
      wr(4'h3, 16'h0000); rd(4'h4, 16'h0000);
      wr(4'h5, 16'h0001); wr(4'h3, 16'h001C); rd(4'h3, 16'h0000);
      wr(4'h5, 16'h0000);
      // Latched start, short pulse refused, long pulse latches
      pin(5'b00110, 4); wr(4'h1, 16'h0006); wr(4'h0, 16'h0008);
      pin(5'b00111, MP / 2); pin(5'b00110, 2 * MP); chk(runCmd, 0);
      pin(5'b00111, 2 * MP); pin(5'b00110, 10); chk(runCmd, 1);
      pin(5'b00100, 3); pin(5'b00110, 10); chk(runCmd, 0);
      // Held reference stepped by speed-up pulses
      wr(4'h3, 16'h000E); wr(4'h4, 16'h0010);
      pin(5'b11110, MP / 2); pin(5'b01110, 2 * MP); chk(nUp, 0);
      pin(5'b11110, 2 * MP); pin(5'b01110, 2 * MP); chk(nUp, 1);
      rd(4'h9, 16'h0100);
      // Preset index from two selects, msb on the fourth terminal
      wr(4'h3, 16'h0017); wr(4'h4, 16'h0016);
      pin(5'b01110, 10); chk(presetIdx, 2'b10);
      // Stop codes, fixed speed, ramp and hold-output seen in status
      wr(4'h6, 16'h0001); wr(4'h7, 16'h0001); wr(4'h0, 16'h0005);
      wr(4'h1, 16'h0004); wr(4'h2, 16'h0015); wr(4'h3, 16'h000D);
      wr(4'h4, 16'h000F);
      pin(5'b01110, 10); rd(4'h8, 16'h0104);
      pin(5'b11111, 10); rd(4'h8, 16'h01A0);
      pin(5'b11101, 10); rd(4'h8, 16'h0182);
      wr(4'h6, 16'h0000); pin(5'b11110, 10); rd(4'h8, 16'h01A0);
      // Closed loop blocks reversing; code 2 coasts on a low level
      wr(4'h5, 16'h0002); wr(4'h1, 16'h0009); pin(5'b11110, 10);
      chk(reverseCmd, 0); wr(4'h5, 16'h0000); pin(5'b11110, 2);
      chk(reverseCmd, 1); wr(4'h0, 16'h0002); pin(5'b11110, 10);
      chk(coastCmd, 1);
      tally_and_finish;
   end
   // Watchdog well beyond the few hundred cycles the scenarios take
   initial begin
      #200000;
      nMismatch++;
      tally_and_finish;
   end
endmodule : drive_digital_input_functions_tb_top
`default_nettype wire
